// ---- hdl/pulse_pin_io_control.sv ----
// General-purpose I/O control of the four pulse generator pins.
// Assumes an Avalon-MM master on mclk_i and pads resolved outside.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Pins sit in bits 16 to 19 and the output status reads 1 where a driver is enabled.
// - A write-only output disable register turns drivers off, which then read 0.
// - Write-only set and clear registers make a pin drive 1 or 0.
// - A read-only register returns the level each pin is commanded to drive.
// - A read-only register returns the level really present on each pin.
// - A write-only register puts a pin into open drain, which then reads 1.
// - A write-only register returns a pin to push-pull, which then reads 0.
// - The I/O control acts only on pins selected for I/O; others carry the pulse output.
// - After reset every pin is in I/O mode with its driver off, acting as an input.
module pulse_pin_io_control
  import pulse_pin_pkg::*;
#(
  parameter int FIELD_LSB = FIELD_LSB_DEF
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [BUS_DW-1:0] avs_writedata_i,
  input wire logic [BUS_BE-1:0] avs_byteenable_i,
  output logic [BUS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pulse generator levels for pins not in I/O mode
  input wire logic [PIN_COUNT-1:0] pulse_level_i,
  // Pads, split into input, output and enable
  input wire logic [PIN_COUNT-1:0] pad_in_i,
  output logic [PIN_COUNT-1:0] pad_out_o,
  output logic [PIN_COUNT-1:0] pad_oe_o,
  // Current selection, for the pulse generator
  output logic [PIN_COUNT-1:0] io_mode_o
);

  // Reject field placements that straddle a byte lane or leave the word
  initial
  begin
    if (FIELD_LSB < 0 || FIELD_LSB + PIN_COUNT > BUS_DW)
    begin
      $error("pulse_pin_io_control: FIELD_LSB out of range");
    end
    if ((FIELD_LSB % 8) + PIN_COUNT > 8)
    begin
      $error("pulse_pin_io_control: pin field must sit in one byte lane");
    end
  end

  localparam int FIELD_LANE = FIELD_LSB / 8;

  // Pin field of a write word, or nothing if its lane is not enabled
  function automatic logic [PIN_COUNT-1:0] field_of(
    input logic [BUS_DW-1:0] data,
    input logic [BUS_BE-1:0] be
  );
    logic [PIN_COUNT-1:0] f;
    f = data[FIELD_LSB +: PIN_COUNT];
    if (!be[FIELD_LANE])
    begin
      f = '0;
    end
    return f;
  endfunction

  // Place a pin field in a read word, all else zero
  function automatic logic [BUS_DW-1:0] word_of(
    input logic [PIN_COUNT-1:0] f
  );
    logic [BUS_DW-1:0] w;
    w = READ_ZERO;
    w[FIELD_LSB +: PIN_COUNT] = f;
    return w;
  endfunction

  // Bus handshake state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

  bus_state_t bus_state;
  bus_state_t next_bus_state;

  pin_ctrl_t ctrl;
  pad_drive_t pad;
  logic [PIN_COUNT-1:0] pin_level;
  logic [BUS_DW-1:0] next_readdata;
  logic wr_commit;
  logic [PIN_COUNT-1:0] wr_field;

  // Decoded write strobes, one per write-only register
  logic wr_sel_en;
  logic wr_sel_dis;
  logic wr_oe_en;
  logic wr_oe_dis;
  logic wr_set;
  logic wr_clr;
  logic wr_od_en;
  logic wr_od_dis;

  // Pad level is asynchronous, so it passes two flops first
  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(pad_in_i),
    .sync_o(pin_level)
  );

  // Pad source selection and open drain handling
  pin_drive u_drive (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ctrl_i(ctrl),
    .pulse_level_i(pulse_level_i),
    .pad_o(pad)
  );

  assign pad_out_o = pad.out;
  assign pad_oe_o = pad.oe;
  assign io_mode_o = ctrl.io_sel;

  // One wait state: the request is taken in IDLE, answered in ANSWER
  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        next_bus_state = BUS_IDLE;
      end
      default:
      begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bus_state <= BUS_IDLE;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end

  // Waitrequest drops in the answer cycle and stays low while no request is pending
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_state != BUS_ANSWER);

  // Writes commit at the edge where waitrequest is low
  assign wr_commit = avs_write_i && (bus_state == BUS_ANSWER);
  assign wr_field = field_of(avs_writedata_i, avs_byteenable_i); // Other bits ignored

  // Address decode of write-only registers
  assign wr_sel_en = wr_commit && (avs_address_i == ADDR_IO_SEL_ENABLE);
  assign wr_sel_dis = wr_commit && (avs_address_i == ADDR_IO_SEL_DISABLE);
  assign wr_oe_en = wr_commit && (avs_address_i == ADDR_PIN_OUTPUT_ENABLE);
  assign wr_oe_dis = wr_commit && (avs_address_i == ADDR_PIN_OUTPUT_DISABLE);
  assign wr_set = wr_commit && (avs_address_i == ADDR_PIN_SET_LEVEL);
  assign wr_clr = wr_commit && (avs_address_i == ADDR_PIN_CLEAR_LEVEL);
  assign wr_od_en = wr_commit && (avs_address_i == ADDR_OPEN_DRAIN_ENABLE);
  assign wr_od_dis = wr_commit && (avs_address_i == ADDR_OPEN_DRAIN_DISABLE);

  // Pin selection; all pins start in I/O mode
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ctrl.io_sel <= IO_SEL_RESET;
    end
    else if (wr_sel_en)
    begin
      ctrl.io_sel <= ctrl.io_sel | wr_field;
    end
    else if (wr_sel_dis)
    begin
      ctrl.io_sel <= ctrl.io_sel & ~wr_field;
    end
  end

  // Output driver enable; drivers off after reset
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ctrl.out_en <= OUTPUT_EN_RESET;
    end
    else if (wr_oe_en)
    begin
      ctrl.out_en <= ctrl.out_en | wr_field;
    end
    else if (wr_oe_dis)
    begin
      ctrl.out_en <= ctrl.out_en & ~wr_field;
    end
  end

  // Commanded level, set and clear by separate writes
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ctrl.level <= LEVEL_RESET;
    end
    else if (wr_set)
    begin
      ctrl.level <= ctrl.level | wr_field;
    end
    else if (wr_clr)
    begin
      ctrl.level <= ctrl.level & ~wr_field;
    end
  end

  // Open drain selection
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ctrl.open_drain <= OPEN_DRAIN_RESET;
    end
    else if (wr_od_en)
    begin
      ctrl.open_drain <= ctrl.open_drain | wr_field;
    end
    else if (wr_od_dis)
    begin
      ctrl.open_drain <= ctrl.open_drain & ~wr_field;
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  always_comb
  begin
    case (avs_address_i)
      ADDR_IO_SEL_STATUS: next_readdata = word_of(ctrl.io_sel);
      ADDR_PIN_OUTPUT_STATUS: next_readdata = word_of(ctrl.out_en);
      ADDR_COMMANDED_LEVEL_STATUS: next_readdata = word_of(ctrl.level);
      ADDR_PIN_ACTUAL_LEVEL: next_readdata = word_of(pin_level);
      ADDR_OPEN_DRAIN_STATUS: next_readdata = word_of(ctrl.open_drain);
      default: next_readdata = READ_ZERO;
    endcase
  end

  // Read data captured while waiting, so it stands in the answer cycle
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= READ_ZERO;
    end
    else if (avs_read_i && bus_state == BUS_IDLE)
    begin
      avs_readdata_o <= next_readdata;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/pulse_pin_pkg.sv ----
// Constants, register map and carrier types for the pulse pin I/O control.
// Assumes a 32-bit Avalon-MM slave port with full byte addresses.
package pulse_pin_pkg;

  localparam int PIN_COUNT = 4;
  localparam int FIELD_LSB_DEF = 16;
  localparam int BUS_AW = 32;
  localparam int BUS_DW = 32;
  localparam int BUS_BE = 4;

  // Register byte addresses
  localparam logic [31:0] ADDR_IO_SEL_ENABLE = 32'hFFFD0000;
  localparam logic [31:0] ADDR_IO_SEL_DISABLE = 32'hFFFD0004;
  localparam logic [31:0] ADDR_IO_SEL_STATUS = 32'hFFFD0008;
  localparam logic [31:0] ADDR_PIN_OUTPUT_ENABLE = 32'hFFFD0010;
  localparam logic [31:0] ADDR_PIN_OUTPUT_DISABLE = 32'hFFFD0014;
  localparam logic [31:0] ADDR_PIN_OUTPUT_STATUS = 32'hFFFD0018;
  localparam logic [31:0] ADDR_PIN_SET_LEVEL = 32'hFFFD0030;
  localparam logic [31:0] ADDR_PIN_CLEAR_LEVEL = 32'hFFFD0034;
  localparam logic [31:0] ADDR_COMMANDED_LEVEL_STATUS = 32'hFFFD0038;
  localparam logic [31:0] ADDR_PIN_ACTUAL_LEVEL = 32'hFFFD003C;
  localparam logic [31:0] ADDR_OPEN_DRAIN_ENABLE = 32'hFFFD0040;
  localparam logic [31:0] ADDR_OPEN_DRAIN_DISABLE = 32'hFFFD0044;
  localparam logic [31:0] ADDR_OPEN_DRAIN_STATUS = 32'hFFFD0048;

  // Reset values of the pin fields
  localparam logic [PIN_COUNT-1:0] IO_SEL_RESET = 4'hF;
  localparam logic [PIN_COUNT-1:0] OUTPUT_EN_RESET = 4'h0;
  localparam logic [PIN_COUNT-1:0] LEVEL_RESET = 4'h0;
  localparam logic [PIN_COUNT-1:0] OPEN_DRAIN_RESET = 4'h0;

  // Value read from unmapped or write-only addresses
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Synchroniser depth on the pad inputs
  localparam int SYNC_STAGES = 2;

  // Per-pin control state, one bit per pin in each field
  typedef struct packed {
    logic [PIN_COUNT-1:0] io_sel;
    logic [PIN_COUNT-1:0] out_en;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] open_drain;
  } pin_ctrl_t;

  // Pad drive for all pins
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } pad_drive_t;

endpackage

// ---- hdl/pin_sync.sv ----
// Two-flop synchroniser for the pad input levels.
// Assumes the pads are asynchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import pulse_pin_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  // First stage feeds only the second
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/pin_drive.sv ----
// Pad drive stage: picks I/O or pulse source and applies open drain.
// Assumes pulse levels come from logic on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_drive
  import pulse_pin_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pin_ctrl_t ctrl_i,
  input wire logic [PIN_COUNT-1:0] pulse_level_i,
  output pad_drive_t pad_o
);

  pad_drive_t next_pad;

  // Per pin source and driver choice
  always_comb
  begin
    next_pad = '0;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (!ctrl_i.io_sel[i])
      begin
        // Pulse mode: generator owns the pin
        next_pad.out[i] = pulse_level_i[i];
        next_pad.oe[i] = 1'b1;
      end
      else if (ctrl_i.open_drain[i])
      begin
        // A high level releases the pin instead of driving it
        next_pad.out[i] = 1'b0;
        next_pad.oe[i] = ctrl_i.out_en[i] & ~ctrl_i.level[i];
      end
      else
      begin
        // Push-pull, driver only when enabled
        next_pad.out[i] = ctrl_i.level[i];
        next_pad.oe[i] = ctrl_i.out_en[i];
      end
    end
  end

  // Registered pad drive; reset leaves all drivers off
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pad_o <= '0;
    end
    else
    begin
      pad_o <= next_pad;
    end
  end

endmodule
`default_nettype wire

// ---- bench/pulse_pin_props.sv ----
// Port-level checker for the pulse pin I/O block.
// Assumes it is bound into pulse_pin_io_control.
`timescale 1ns/1ps
`default_nettype none
module pulse_pin_props
  import pulse_pin_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [BUS_DW-1:0] avs_writedata_i,
  input wire logic [BUS_BE-1:0] avs_byteenable_i,
  input wire logic [BUS_DW-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [PIN_COUNT-1:0] pulse_level_i,
  input wire logic [PIN_COUNT-1:0] pad_in_i,
  input wire logic [PIN_COUNT-1:0] pad_out_o,
  input wire logic [PIN_COUNT-1:0] pad_oe_o,
  input wire logic [PIN_COUNT-1:0] io_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] last_in;
  logic [2:0] calm;
  logic ans;
  assign ans = !avs_waitrequest_o;
  // Counts edges the pads stay still, so the synchroniser lag is covered
  always_ff @(posedge mclk_i)
  begin
    last_in <= pad_in_i;
    if (rst_i || pad_in_i != last_in)
      calm <= 3'h0;
    else if (calm != 3'h7)
      calm <= calm + 3'h1;
  end
  a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> ans)
    else $error("wait lasted more than one cycle");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i |-> ans)
    else $error("wait raised with no request");
  a_reset_state: assert property ($fell(rst_i) |-> pad_oe_o == 4'h0 && io_mode_o == 4'hF)
    else $error("pins not inputs in I/O mode after reset");
  a_reserved_zero: assert property (avs_read_i && ans |->
    avs_readdata_o[31:20] == 12'h000 && avs_readdata_o[15:0] == 16'h0000)
    else $error("reserved read bits not zero");
  a_pulse_pass: assert property (io_mode_o == 4'h0 && $past(io_mode_o) == 4'h0 |->
    pad_oe_o == 4'hF && pad_out_o == $past(pulse_level_i))
    else $error("pulse level not on pads");
  a_pin_level: assert property (avs_read_i && ans && avs_address_i == ADDR_PIN_ACTUAL_LEVEL
    && calm >= 3'h4 |-> avs_readdata_o[19:16] == pad_in_i)
    else $error("pin level read differs from pads");
  a_clear_low: assert property (avs_write_i && ans && avs_address_i == ADDR_PIN_CLEAR_LEVEL
    && avs_byteenable_i[2] |->
    ##2 (pad_out_o & io_mode_o & $past(avs_writedata_i[19:16], 2)) == 4'h0)
    else $error("cleared pin still drives high");
  a_data_holds: assert property (!avs_read_i [*2] |-> $stable(avs_readdata_o))
    else $error("read data moved without a read");
endmodule
bind pulse_pin_io_control pulse_pin_props i_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pulse_level_i(pulse_level_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .io_mode_o(io_mode_o));
`default_nettype wire

// ---- bench/pad_board.sv ----
// Board model of the four pads: pull-ups and a switch to ground.
// Assumes pad drive split into value and enable.
`timescale 1ns/1ps
`default_nettype none
module pad_board
  import pulse_pin_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] out_i,
  input wire logic [PIN_COUNT-1:0] oe_i,
  input wire logic [PIN_COUNT-1:0] ground_i,
  output logic [PIN_COUNT-1:0] level_o
);
  // Pull-up only where nobody drives; the switch beats a driven high
  always_comb
  begin
    level_o = (out_i | ~oe_i) & ~ground_i;
  end
endmodule
`default_nettype wire

// ---- bench/pulse_pin_io_control_test.sv ----
// Self-checking bench for the pulse pin I/O block.
// Assumes the board model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module pulse_pin_io_control_test
  import pulse_pin_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] addr = 32'h00000000;
  logic [31:0] wdata = 32'h00000000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] pulse = 4'h0;
  logic [3:0] ground = 4'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitreq;
  logic [3:0] pad_out, pad_oe, io_mode, pad_level;
  int fails = 0;
  int cmp_count = 0;
  pulse_pin_io_control i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .pulse_level_i(pulse),
    .pad_in_i(pad_level), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .io_mode_o(io_mode));
  pad_board i_board (.out_i(pad_out), .oe_i(pad_oe), .ground_i(ground), .level_o(pad_level));
  // Clock, 10 ns period
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pads are registered, so look at them mid-cycle where they have settled
  task automatic pchk(input logic [31:0] exp);
    @(negedge mclk_i);
    check({20'h00000, io_mode, pad_oe, pad_out}, exp);
    @(posedge mclk_i);
  endtask
  // One Avalon cycle; wait and read data are taken at the same rising edge
  task automatic bus(input logic we, input logic [31:0] a, d, output logic [31:0] q);
    logic w;
    int n;
    w = 1'b1;
    n = 0;
    q = 32'h00000000;
    addr <= a;
    wdata <= d;
    rd <= !we;
    wr <= we;
    while (w !== 1'b0 && n < 20)
    begin
      @(posedge mclk_i);
      w = waitreq;
      q = rdata;
      n++;
    end
    if (w !== 1'b0)
      fails++;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wreg(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask
  task automatic t_reset;
    rchk(ADDR_PIN_OUTPUT_STATUS, 32'h00000000);
    rchk(ADDR_IO_SEL_STATUS, 32'h000F0000);
    rchk(ADDR_OPEN_DRAIN_STATUS, 32'h00000000);
    rchk(ADDR_COMMANDED_LEVEL_STATUS, 32'h00000000);
    rchk(ADDR_PIN_SET_LEVEL, 32'h00000000);
    rchk(32'hFFFD000C, 32'h00000000);
    rchk(ADDR_PIN_ACTUAL_LEVEL, 32'h000F0000);
    pchk(32'h00000F00);
    $display("reset test done");
  endtask
  task automatic t_push;
    wreg(ADDR_PIN_OUTPUT_ENABLE, 32'h000F0000);
    rchk(ADDR_PIN_OUTPUT_STATUS, 32'h000F0000);
    wreg(ADDR_PIN_SET_LEVEL, 32'hFFF5FFFF);
    rchk(ADDR_COMMANDED_LEVEL_STATUS, 32'h00050000);
    pchk(32'h00000FF5);
    rchk(ADDR_PIN_ACTUAL_LEVEL, 32'h00050000);
    wreg(ADDR_PIN_CLEAR_LEVEL, 32'h00010000);
    rchk(ADDR_COMMANDED_LEVEL_STATUS, 32'h00040000);
    be <= 4'hB;
    wreg(ADDR_PIN_SET_LEVEL, 32'h000F0000);
    be <= 4'hF;
    rchk(ADDR_COMMANDED_LEVEL_STATUS, 32'h00040000);
    wreg(ADDR_PIN_OUTPUT_DISABLE, 32'h000C0000);
    rchk(ADDR_PIN_OUTPUT_STATUS, 32'h00030000);
    repeat (3) @(posedge mclk_i);
    rchk(ADDR_PIN_ACTUAL_LEVEL, 32'h000C0000);
    $display("push-pull test done");
  endtask
  task automatic t_open_drain;
    wreg(ADDR_PIN_OUTPUT_ENABLE, 32'h000F0000);
    wreg(ADDR_OPEN_DRAIN_ENABLE, 32'h000F0000);
    rchk(ADDR_OPEN_DRAIN_STATUS, 32'h000F0000);
    wreg(ADDR_PIN_SET_LEVEL, 32'h000F0000);
    ground <= 4'h2;
    repeat (4) @(posedge mclk_i);
    pchk(32'h00000F00);
    rchk(ADDR_PIN_ACTUAL_LEVEL, 32'h000D0000);
    wreg(ADDR_PIN_CLEAR_LEVEL, 32'h00010000);
    pchk(32'h00000F10);
    ground <= 4'h0;
    wreg(ADDR_OPEN_DRAIN_DISABLE, 32'h000F0000);
    rchk(ADDR_OPEN_DRAIN_STATUS, 32'h00000000);
    pchk(32'h00000FFE);
    $display("open drain test done");
  endtask
  task automatic t_pulse;
    pulse <= 4'hA;
    wreg(ADDR_IO_SEL_DISABLE, 32'h000F0000);
    rchk(ADDR_IO_SEL_STATUS, 32'h00000000);
    pchk(32'h000000FA);
    wreg(ADDR_IO_SEL_ENABLE, 32'h000F0000);
    repeat (2) @(posedge mclk_i);
    pchk(32'h00000FFE);
    $display("pulse mode test done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_reset;
    t_push;
    t_open_drain;
    t_pulse;
    conclude;
  end
  // Watchdog, far beyond the roughly 120 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge mclk_i);
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
